/* File: dv/ufr_ctrl_partner.sv */
// Purpose: Controller-side partner answering the frame start handshakes
// Assumes: Requests are one-cycle pulses on sys_clk
// Notes: Lag sets how slowly each answer comes back
`timescale 1ns/1ps
`default_nettype none
module ufr_ctrl_partner (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sof_request,
  input wire logic frame_store_req,
  input wire logic [15:0] frame_store_value,
  input wire logic [3:0] lag,
  output logic sof_sent,
  output logic frame_store_ack,
  output logic [15:0] stored_count,
  output logic [7:0] store_total
);
  // ----------------------------------------------------------------
  // Handshake answers
  // ----------------------------------------------------------------
  // Start-of-frame goes out before the count is stored, never overlapped
  initial begin
    sof_sent = 1'b0;
    frame_store_ack = 1'b0;
    stored_count = 16'h0000;
    store_total = 8'h00;
    forever begin
      @(posedge sys_clk);
      if (resetn === 1'b1 && sof_request === 1'b1) begin
        repeat (lag) @(posedge sys_clk);
        sof_sent <= 1'b1;
        @(posedge sys_clk);
        sof_sent <= 1'b0;
      end
      if (resetn === 1'b1 && frame_store_req === 1'b1) begin
        stored_count <= frame_store_value;
        store_total <= store_total + 8'h01;
        repeat (lag) @(posedge sys_clk);
        frame_store_ack <= 1'b1;
        @(posedge sys_clk);
        frame_store_ack <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/usb_host_frame_and_list_regs_test.sv */
// Purpose: Self-checking bench for the frame timing and list register block
// Assumes: Slave may insert wait states; bit_tick and td_done are held high over several cycles
// Notes: Interval shrunk to 20 bit times so frames stay short
`timescale 1ns/1ps
`default_nettype none
module usb_host_frame_and_list_regs_test;
  logic sys_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, next_descriptor_link, head_ptr = 32'h0, ed_addr = 32'h0;
  logic [31:0] td_addr = 32'h0;
  logic [1:0] htrans = 2'b00, pset = 2'b00, pclr = 2'b00, pmask = 2'b00, port_powered;
  logic [2:0] hsize = 3'b010;
  logic [3:0] lag = 4'h0;
  logic [14:0] lpc;
  logic [15:0] fs_value, stored_count;
  logic [7:0] store_total;
  logic hreadyout, hresp, tick = 1'b0, hc_rst = 1'b0, enter_op = 1'b0, ben = 1'b0, bfill = 1'b0;
  logic ed_served = 1'b0, bend = 1'b0, td_done = 1'b0, dstore = 1'b0, xfer = 1'b0, gset = 1'b0, gclr = 1'b0;
  logic bclr, link_write, wb_event, sof_req, fs_req, sof_event, hold, pprio, slow_ok, sof_sent, fs_ack;
  int fails = 0, check_count = 0, sof_seen = 0;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sof_event === 1'b1) sof_seen++;
  ufr_frame_regs dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .bit_tick(tick), .hc_reset_cmd(hc_rst), .enter_operational(enter_op),
    .bulk_list_enable(ben), .bulk_list_filled(bfill), .bulk_list_head_pointer(head_ptr), .ed_served(ed_served),
    .next_ed_addr(ed_addr), .bulk_list_end(bend), .td_done(td_done), .td_addr(td_addr),
    .done_head_store(dstore), .sof_sent(sof_sent), .frame_store_ack(fs_ack), .xfer_bit_active(xfer),
    .global_power_set(gset), .global_power_clear(gclr), .port_power_set(pset), .port_power_clear(pclr),
    .port_power_mask(pmask), .bulk_filled_clear(bclr), .next_descriptor_link(next_descriptor_link),
    .link_write(link_write), .writeback_done_event(wb_event), .sof_request(sof_req), .frame_store_req(fs_req),
    .frame_store_value(fs_value), .sof_event(sof_event), .ed_fetch_hold(hold), .periodic_priority(pprio),
    .slow_transfer_ok(slow_ok), .largest_packet_count(lpc), .port_powered(port_powered));
  ufr_ctrl_partner partner (.sys_clk(sys_clk), .resetn(resetn), .sof_request(sof_req),
    .frame_store_req(fs_req), .frame_store_value(fs_value), .lag(lag), .sof_sent(sof_sent),
    .frame_store_ack(fs_ack), .stored_count(stored_count), .store_total(store_total));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Waits on hreadyout at both phases; a zero-wait slave is not assumed
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel <= 1'b1; haddr <= {20'h00000, a}; htrans <= 2'b10; hwrite <= w; hsize <= 3'b010;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk($sformatf("reg_%h", a), d, exp);
  endtask
  task automatic ticks(input int n);
    tick <= 1'b1;
    repeat (n) @(posedge sys_clk);
    tick <= 1'b0;
    @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    rchk(ufr_pkg::OFS_BULK_CUR, 32'h0);
    rchk(ufr_pkg::OFS_DONE_HEAD, 32'h0);
    rchk(ufr_pkg::OFS_FRAME_PERIOD, 32'h00002edf);
    rchk(ufr_pkg::OFS_FRAME_COUNT, 32'h0);
    rchk(ufr_pkg::OFS_PERIODIC_START, 32'h0);
    rchk(ufr_pkg::OFS_HUB_DESC_A, 32'h00000002);
    rchk(12'h550, 32'h0);
  endtask
  task automatic t_fields();
    wr(ufr_pkg::OFS_PERIODIC_START, 32'hffffffff);
    rchk(ufr_pkg::OFS_PERIODIC_START, 32'h00003fff);
    wr(ufr_pkg::OFS_HUB_DESC_A, 32'hffffffff);
    rchk(ufr_pkg::OFS_HUB_DESC_A, 32'hff001b02);
    wr(ufr_pkg::OFS_FRAME_LEFT, 32'h00000123);
    rchk(ufr_pkg::OFS_FRAME_LEFT, 32'h0);
    wr(ufr_pkg::OFS_SLOW_CUTOFF, 32'hfffff005);
    wr(ufr_pkg::OFS_SLOW_CUTOFF, 32'h00000fff);
    rchk(ufr_pkg::OFS_SLOW_CUTOFF, 32'h00000005);
  endtask
  task automatic t_bulk();
    wr(ufr_pkg::OFS_BULK_CUR, 32'h1234567f);
    rchk(ufr_pkg::OFS_BULK_CUR, 32'h12345670);
    ben <= 1'b1;
    wr(ufr_pkg::OFS_BULK_CUR, 32'habcdef00);
    rchk(ufr_pkg::OFS_BULK_CUR, 32'h12345670);
    ed_served <= 1'b1; ed_addr <= 32'h0000a5a9;
    @(posedge sys_clk);
    ed_served <= 1'b0;
    rchk(ufr_pkg::OFS_BULK_CUR, 32'h0000a5a0);
    head_ptr <= 32'h00c0ffe4; bend <= 1'b1;
    @(posedge sys_clk);
    bend <= 1'b0;
    @(posedge sys_clk);
    chk("bulk_filled_clear", {31'h0, bclr}, 32'h0);
    rchk(ufr_pkg::OFS_BULK_CUR, 32'h0000a5a0);
    bfill <= 1'b1; bend <= 1'b1;
    @(posedge sys_clk);
    bend <= 1'b0;
    @(posedge sys_clk);
    chk("bulk_filled_clear", {31'h0, bclr}, 32'h1);
    rchk(ufr_pkg::OFS_BULK_CUR, 32'h00c0ffe0);
    bfill <= 1'b0; ben <= 1'b0;
  endtask
  task automatic t_done();
    td_done <= 1'b1; td_addr <= 32'h00001110;
    @(posedge sys_clk);
    td_addr <= 32'h00002220;
    @(posedge sys_clk);
    td_done <= 1'b0;
    chk("link_write", {31'h0, link_write}, 32'h1);
    chk("link", next_descriptor_link, 32'h0);
    @(posedge sys_clk);
    chk("link", next_descriptor_link, 32'h00001110);
    rchk(ufr_pkg::OFS_DONE_HEAD, 32'h00002220);
    dstore <= 1'b1;
    @(posedge sys_clk);
    dstore <= 1'b0;
    @(posedge sys_clk);
    chk("writeback_event", {31'h0, wb_event}, 32'h1);
    rchk(ufr_pkg::OFS_DONE_HEAD, 32'h0);
  endtask
  task automatic t_frame();
    wr(ufr_pkg::OFS_PERIODIC_START, 32'h0000000a);
    wr(ufr_pkg::OFS_FRAME_PERIOD, 32'h80640014);
    hc_rst <= 1'b1;
    @(posedge sys_clk);
    hc_rst <= 1'b0;
    rchk(ufr_pkg::OFS_FRAME_PERIOD, 32'h00002edf);
    wr(ufr_pkg::OFS_FRAME_PERIOD, 32'h80640014);
    enter_op <= 1'b1;
    @(posedge sys_clk);
    enter_op <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rchk(ufr_pkg::OFS_FRAME_LEFT, 32'h00000014);
    rchk(ufr_pkg::OFS_FRAME_COUNT, 32'h00000001);
    chk("stored_count", {16'h0, stored_count}, 32'h1);
    chk("sof_events", sof_seen, 32'h1);
    ticks(11);
    chk("periodic_priority", {31'h0, pprio}, 32'h1);
    chk("slow_ok", {31'h0, slow_ok}, 32'h1);
    ticks(5);
    // Flag is registered; one more edge after the idle edge that closes ticks lets it reflect the last count
    @(posedge sys_clk);
    chk("slow_ok", {31'h0, slow_ok}, 32'h0);
    lag <= 4'h3;
    ticks(5);
    chk("fetch_hold", {31'h0, hold}, 32'h1);
    repeat (16) @(posedge sys_clk);
    chk("fetch_hold", {31'h0, hold}, 32'h0);
    chk("store_total", {24'h0, store_total}, 32'h2);
    rchk(ufr_pkg::OFS_FRAME_LEFT, 32'h80000014);
    rchk(ufr_pkg::OFS_FRAME_COUNT, 32'h00000002);
    chk("periodic_priority", {31'h0, pprio}, 32'h0);
    chk("largest_packet", {17'h0, lpc}, 32'h00000064);
    chk("stored_count", {16'h0, stored_count}, 32'h2);
    chk("sof_events", sof_seen, 32'h2);
    xfer <= 1'b1;
    ticks(3);
    xfer <= 1'b0;
    chk("largest_packet", {17'h0, lpc}, 32'h00000061);
    rchk(ufr_pkg::OFS_FRAME_LEFT, 32'h80000011);
  endtask
  task automatic t_power();
    wr(ufr_pkg::OFS_HUB_DESC_A, 32'h00000000);
    gset <= 1'b1;
    @(posedge sys_clk);
    gset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("ports", {30'h0, port_powered}, 32'h3);
    wr(ufr_pkg::OFS_HUB_DESC_A, 32'h00000100);
    pmask <= 2'b01; gclr <= 1'b1;
    @(posedge sys_clk);
    gclr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("ports", {30'h0, port_powered}, 32'h1);
    pclr <= 2'b11;
    @(posedge sys_clk);
    pclr <= 2'b00;
    repeat (2) @(posedge sys_clk);
    chk("ports", {30'h0, port_powered}, 32'h0);
    // Unmasked port must ignore per-port commands
    pset <= 2'b11;
    @(posedge sys_clk);
    pset <= 2'b00;
    repeat (2) @(posedge sys_clk);
    chk("ports", {30'h0, port_powered}, 32'h1);
  endtask
  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset_vals();
    t_fields();
    t_bulk();
    t_done();
    t_frame();
    t_power();
    close_out();
  end
  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire

/* File: hw/ufr_frame_regs.sv */
// Purpose: Bulk pointer, done queue head, frame timing and hub descriptor A
// Assumes: Side-band inputs come from controller logic on sys_clk
// Notes: AHB-Lite slave answers with zero wait states
//
// Overview of operation
// - Bulk pointer advances per served descriptor; at list end reloads head if filled.
// - Bulk pointer resets to zero; zero marks end of bulk list.
// - Completed descriptor gets old done head as link; head becomes its address.
// - Writing done head to common memory clears it and flags writeback event.
// - Frame interval holds bit times per frame, nominally 11999.
// - Host controller reset restores nominal interval; software may save and restore.
// - Largest packet value loads into a counter at each frame start.
// - Frame time left counts down per bit time, reloads interval after zero.
// - Entering operational state reloads frame time left from the interval.
// - Frame time left toggle copies interval marker whenever count reaches zero.
// - Frame count increments on each reload and wraps after ffff.
// - Frame count increments on entering operational state.
// - After increment and start-of-frame, store frame count, then flag event.
// - Periodic start clears on reset and is set by software.
// - From periodic start point on, periodic lists take priority.
// - Slow transfer starts only if frame time left is at least cutoff.
// - Slow transfer cutoff may not change once it has been set.
// - Hub registers take whole word accesses, descriptor A writable always.
// - Downstream port count reads two and is read-only.
// - Power mode selects ganged or per-port power with mask selection.
`timescale 1ns/1ps
`default_nettype none
module ufr_frame_regs (
  input wire logic sys_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Controller side-band
  input wire logic bit_tick,
  input wire logic hc_reset_cmd,
  input wire logic enter_operational,
  input wire logic bulk_list_enable,
  input wire logic bulk_list_filled,
  input wire logic [31:0] bulk_list_head_pointer,
  input wire logic ed_served,
  input wire logic [31:0] next_ed_addr,
  input wire logic bulk_list_end,
  input wire logic td_done,
  input wire logic [31:0] td_addr,
  input wire logic done_head_store,
  input wire logic sof_sent,
  input wire logic frame_store_ack,
  input wire logic xfer_bit_active,
  input wire logic global_power_set,
  input wire logic global_power_clear,
  input wire logic [1:0] port_power_set,
  input wire logic [1:0] port_power_clear,
  input wire logic [1:0] port_power_mask,
  output logic bulk_filled_clear,
  output logic [31:0] next_descriptor_link,
  output logic link_write,
  output logic writeback_done_event,
  output logic sof_request,
  output logic frame_store_req,
  output logic [15:0] frame_store_value,
  output logic sof_event,
  output logic ed_fetch_hold,
  output logic periodic_priority,
  output logic slow_transfer_ok,
  output logic [14:0] largest_packet_count,
  output logic [1:0] port_powered
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:4] bulk_cur_q;
  logic [31:4] done_head_q;
  logic [13:0] interval_q;
  logic [14:0] ldp_q;
  logic itoggle_q;
  logic [13:0] left_q;
  logic ltoggle_q;
  logic [15:0] fcount_q;
  logic [13:0] pstart_q;
  logic [11:0] cutoff_q;
  logic cutoff_set_q;
  logic [31:0] hub_a_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic frame_edge;
  logic [31:0] rd_mux;
  logic addr_phase;
  logic wr_hit;
  ufr_pkg::ufr_fseq_e fseq_q;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign addr_phase = hsel && hready && htrans[1];
  // Sub-word writes are dropped so hub registers only change as dwords
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_phase && hwrite && (hsize == 3'b010);
      wr_addr_q <= {haddr[11:2], 2'b00};
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case ({haddr[11:2], 2'b00})
      ufr_pkg::OFS_BULK_CUR: rd_mux = {bulk_cur_q, 4'h0};
      ufr_pkg::OFS_DONE_HEAD: rd_mux = {done_head_q, 4'h0};
      ufr_pkg::OFS_FRAME_PERIOD: rd_mux = {itoggle_q, ldp_q, 2'b00, interval_q};
      ufr_pkg::OFS_FRAME_LEFT: rd_mux = {ltoggle_q, 17'h00000, left_q};
      ufr_pkg::OFS_FRAME_COUNT: rd_mux = {16'h0000, fcount_q};
      ufr_pkg::OFS_PERIODIC_START: rd_mux = {18'h00000, pstart_q};
      ufr_pkg::OFS_SLOW_CUTOFF: rd_mux = {20'h00000, cutoff_q};
      ufr_pkg::OFS_HUB_DESC_A: rd_mux = (hub_a_q & ufr_pkg::HUB_A_WMASK) | {24'h000000, ufr_pkg::DOWNSTREAM_PORTS};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (addr_phase && !hwrite) ? rd_mux : 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign wr_hit = wr_pend_q;

  // ----------------------------------------------------------------
  // Bulk list pointer and done queue
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bulk_cur_q <= 28'h0000000;
      bulk_filled_clear <= 1'b0;
    end else begin
      bulk_filled_clear <= 1'b0;
      if (bulk_list_end) begin
        if (bulk_list_filled) begin
          bulk_cur_q <= bulk_list_head_pointer[31:4];
          bulk_filled_clear <= 1'b1;
        end
      end else if (ed_served) begin
        bulk_cur_q <= next_ed_addr[31:4];
      end else if (wr_hit && wr_addr_q == ufr_pkg::OFS_BULK_CUR && !bulk_list_enable) begin
        bulk_cur_q <= hwdata[31:4];
      end
    end
  end

  // A completion in the same cycle as a store wins: its address is the new head
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      done_head_q <= 28'h0000000;
      next_descriptor_link <= 32'h00000000;
      link_write <= 1'b0;
      writeback_done_event <= 1'b0;
    end else begin
      link_write <= td_done;
      writeback_done_event <= done_head_store;
      if (td_done) begin
        next_descriptor_link <= {done_head_q, 4'h0};
        done_head_q <= td_addr[31:4];
      end else if (done_head_store) begin
        done_head_q <= 28'h0000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame period setting and static registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn || hc_reset_cmd) begin
      interval_q <= ufr_pkg::FRAME_INTERVAL_NOMINAL;
      ldp_q <= 15'h0000;
      itoggle_q <= 1'b0;
    end else if (wr_hit && wr_addr_q == ufr_pkg::OFS_FRAME_PERIOD) begin
      interval_q <= hwdata[13:0];
      ldp_q <= hwdata[ufr_pkg::LDP_MSB:ufr_pkg::LDP_LSB];
      itoggle_q <= hwdata[ufr_pkg::TOGGLE_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pstart_q <= ufr_pkg::PERIODIC_START_RST;
    end else if (wr_hit && wr_addr_q == ufr_pkg::OFS_PERIODIC_START) begin
      pstart_q <= hwdata[13:0];
    end
  end

  // Write-once: later writes are dropped so the cutoff cannot drift
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cutoff_q <= ufr_pkg::CUTOFF_RST;
      cutoff_set_q <= 1'b0;
    end else if (wr_hit && wr_addr_q == ufr_pkg::OFS_SLOW_CUTOFF && !cutoff_set_q) begin
      cutoff_q <= hwdata[11:0];
      cutoff_set_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hub_a_q <= ufr_pkg::HUB_A_RST;
    end else if (wr_hit && wr_addr_q == ufr_pkg::OFS_HUB_DESC_A) begin
      hub_a_q <= hwdata & ufr_pkg::HUB_A_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------
  assign frame_edge = bit_tick && (left_q == 14'h0000);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      left_q <= 14'h0000;
      ltoggle_q <= 1'b0;
      fcount_q <= ufr_pkg::FCOUNT_RST;
    end else if (enter_operational) begin
      left_q <= interval_q;
      fcount_q <= fcount_q + 16'h0001;
    end else if (frame_edge) begin
      left_q <= interval_q;
      ltoggle_q <= itoggle_q;
      fcount_q <= fcount_q + 16'h0001;
    end else if (bit_tick) begin
      left_q <= left_q - 14'h0001;
    end
  end

  // Counter runs only while a transaction moves bits on the wire
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      largest_packet_count <= 15'h0000;
    end else if (frame_edge || enter_operational) begin
      largest_packet_count <= ldp_q;
    end else if (bit_tick && xfer_bit_active && largest_packet_count != 15'h0000) begin
      largest_packet_count <= largest_packet_count - 15'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      periodic_priority <= 1'b0;
      slow_transfer_ok <= 1'b0;
    end else begin
      if (frame_edge || enter_operational) begin
        periodic_priority <= 1'b0;
      end else if (bit_tick && left_q == pstart_q) begin
        periodic_priority <= 1'b1;
      end
      slow_transfer_ok <= ({2'b00, left_q} >= {4'h0, cutoff_q}) || (left_q[13:12] != 2'b00);
    end
  end

  // ----------------------------------------------------------------
  // Frame start sequence
  // ----------------------------------------------------------------
  // Descriptor fetch is held off until the count reaches common memory
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fseq_q <= ufr_pkg::FS_IDLE;
      sof_request <= 1'b0;
      frame_store_req <= 1'b0;
      frame_store_value <= 16'h0000;
      sof_event <= 1'b0;
      ed_fetch_hold <= 1'b0;
    end else begin
      sof_request <= 1'b0;
      frame_store_req <= 1'b0;
      sof_event <= 1'b0;
      case (fseq_q)
        ufr_pkg::FS_IDLE: begin
          if (frame_edge || enter_operational) begin
            sof_request <= 1'b1;
            ed_fetch_hold <= 1'b1;
            fseq_q <= ufr_pkg::FS_SOF;
          end
        end
        ufr_pkg::FS_SOF: begin
          if (sof_sent) begin
            frame_store_req <= 1'b1;
            frame_store_value <= fcount_q;
            fseq_q <= ufr_pkg::FS_STORE;
          end
        end
        ufr_pkg::FS_STORE: begin
          if (frame_store_ack) begin
            sof_event <= 1'b1;
            ed_fetch_hold <= 1'b0;
            fseq_q <= ufr_pkg::FS_IDLE;
          end
        end
        default: fseq_q <= ufr_pkg::FS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Port power
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < ufr_pkg::NUM_PORTS; gp++) begin : g_port
      logic per_port;
      assign per_port = hub_a_q[ufr_pkg::PSM_BIT] && port_power_mask[gp];
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          port_powered[gp] <= 1'b0;
        end else if (per_port) begin
          if (port_power_set[gp]) begin
            port_powered[gp] <= 1'b1;
          end else if (port_power_clear[gp]) begin
            port_powered[gp] <= 1'b0;
          end
        end else if (global_power_set) begin
          port_powered[gp] <= 1'b1;
        end else if (global_power_clear) begin
          port_powered[gp] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_bulk_reload: assert property (@(posedge sys_clk) disable iff (!resetn)
    bulk_list_end && bulk_list_filled |=> bulk_cur_q == $past(bulk_list_head_pointer[31:4]) && bulk_filled_clear)
    else $error("bulk pointer not reloaded from head");
  a_bulk_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
    bulk_list_enable && !ed_served && !bulk_list_end |=> $stable(bulk_cur_q))
    else $error("bulk pointer changed while list enabled");
  a_done_link: assert property (@(posedge sys_clk) disable iff (!resetn)
    td_done |=> next_descriptor_link[31:4] == $past(done_head_q) && done_head_q == $past(td_addr[31:4]))
    else $error("done queue link order wrong");
  a_done_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    done_head_store && !td_done |=> done_head_q == 28'h0000000 && writeback_done_event)
    else $error("done head not cleared on store");
  a_interval_nominal: assert property (@(posedge sys_clk) disable iff (!resetn)
    hc_reset_cmd |=> interval_q == 14'h2edf)
    else $error("interval not nominal after controller reset");
  a_left_reload: assert property (@(posedge sys_clk) disable iff (!resetn)
    frame_edge && !enter_operational |=> left_q == $past(interval_q) && ltoggle_q == $past(itoggle_q))
    else $error("frame time left reload wrong");
  a_count_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    frame_edge |=> fcount_q == $past(fcount_q) + 16'h0001)
    else $error("frame count did not step");
  a_sof_order: assert property (@(posedge sys_clk) disable iff (!resetn)
    frame_store_req |-> ed_fetch_hold && !sof_event)
    else $error("frame store outside hold window");
  a_cutoff_fixed: assert property (@(posedge sys_clk) disable iff (!resetn)
    cutoff_set_q |=> $stable(cutoff_q))
    else $error("slow cutoff changed after set");
  a_port_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    addr_phase && !hwrite && {haddr[11:2], 2'b00} == 12'h548 |=> hrdata[7:0] == 8'h02)
    else $error("port count not two");
  c_bulk_reload: cover property (@(posedge sys_clk) bulk_list_end && bulk_list_filled);
  c_frame_wrap: cover property (@(posedge sys_clk) frame_edge && fcount_q == 16'hffff);
  c_sof_done: cover property (@(posedge sys_clk) sof_event);
  c_priority: cover property (@(posedge sys_clk) $rose(periodic_priority));
endmodule
`default_nettype wire

/* File: hw/ufr_pkg.sv */
// Purpose: Constants for the frame timing and list pointer register block
// Assumes: 32-bit AHB-Lite register access, word aligned
// Notes: Offsets are byte addresses within the controller window
package ufr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_BULK_CUR = 12'h52c;
  localparam logic [11:0] OFS_DONE_HEAD = 12'h530;
  localparam logic [11:0] OFS_FRAME_PERIOD = 12'h534;
  localparam logic [11:0] OFS_FRAME_LEFT = 12'h538;
  localparam logic [11:0] OFS_FRAME_COUNT = 12'h53c;
  localparam logic [11:0] OFS_PERIODIC_START = 12'h540;
  localparam logic [11:0] OFS_SLOW_CUTOFF = 12'h544;
  localparam logic [11:0] OFS_HUB_DESC_A = 12'h548;
  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int PTR_LSB = 4;
  localparam int INTERVAL_W = 14;
  localparam int LDP_LSB = 16;
  localparam int LDP_MSB = 30;
  localparam int TOGGLE_BIT = 31;
  localparam int FCOUNT_W = 16;
  localparam int CUTOFF_W = 12;
  localparam int PSM_BIT = 8;
  localparam int NUM_PORTS = 2;
  // Writable bits of hub descriptor A: 31:24, 12, 11, 9, 8
  localparam logic [31:0] HUB_A_WMASK = 32'hff001b00;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [13:0] FRAME_INTERVAL_NOMINAL = 14'h2edf;
  localparam logic [13:0] PERIODIC_START_RST = 14'h0000;
  localparam logic [11:0] CUTOFF_RST = 12'h000;
  localparam logic [7:0] DOWNSTREAM_PORTS = 8'h02;
  localparam logic [31:0] HUB_A_RST = 32'h00000000;
  localparam logic [15:0] FCOUNT_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Frame start sequence
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FS_IDLE, FS_SOF, FS_STORE} ufr_fseq_e;
endpackage
